// file: cbo_ext_equip.sv
// External equipment on the aux connector, counting line changes as triggers.
// Assumes the lines are sampled on the system clock's rising edge.
`timescale 1ns/1ps
module cbo_ext_equip (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_lines,
    output int              o_edges
);
    logic [7:0] seen = 8'h00;
    int         edge_cnt = 0;
    // Any change between sweep events would be a false trigger downstream
    always @(posedge i_mclk) begin
        if (i_lines !== seen) edge_cnt <= edge_cnt + 1;
        seen <= i_lines;
    end
    assign o_edges = edge_cnt;
endmodule

// file: cbo_pkg.sv
// Package for the channel bit output port: widths, reset values, structs.
// Assumes a single system clock domain; no software-visible registers.
package cbo_pkg;
    localparam int          CBO_NUM_CH      = 8;
    localparam int          CBO_CH_W        = 3;
    localparam int          CBO_LINES       = 8;
    localparam int          CBO_LOW_W       = 4;
    localparam int          CBO_DRV_PORTS   = 4;
    localparam logic [7:0]  CBO_VALUE_RST   = 8'h00;
    localparam logic        CBO_UPPER_RST   = 1'b1;

    // Write of one channel's stored value
    typedef struct packed {
        logic                valid;
        logic [CBO_CH_W-1:0] chan;
        logic [7:0]          value;
    } cbo_wr_t;

    // Sweep activity reported by the measurement sequencer
    typedef struct packed {
        logic                start;
        logic [CBO_CH_W-1:0] chan;
        logic                idle;
    } cbo_sweep_t;
endpackage

// file: cbo_port.sv
// Top of the auxiliary connector output port.
// Assumes sweep, write and select inputs are synchronous to i_mclk.
`timescale 1ns/1ps
module cbo_port #(
    parameter int NUM_CH = cbo_pkg::CBO_NUM_CH,
    parameter int CH_W   = cbo_pkg::CBO_CH_W
) (
    input  wire logic                              i_mclk,
    input  wire logic                              i_sys_rst,
    input  wire cbo_pkg::cbo_wr_t                  i_wr,
    input  wire logic [CH_W-1:0]                   i_query_chan,
    output logic [7:0]                             o_query_value,
    input  wire cbo_pkg::cbo_sweep_t               i_sweep,
    input  wire logic                              i_upper_line_source_select,
    input  wire logic                              i_upper_select_wr,
    input  wire logic [cbo_pkg::CBO_DRV_PORTS-1:0] i_drive_port,
    output logic                                   o_upper_line_source_select,
    output logic [cbo_pkg::CBO_LINES-1:0]          o_aux_connector_output_value
);
    import cbo_pkg::*;

    logic [7:0]                  sweep_value;
    logic [CH_W-1:0]             shown_chan_reg;
    logic [CH_W-1:0]             shown_chan_next;
    logic [7:0]                  ch_value_reg;
    logic [7:0]                  ch_value_next;
    logic                        sel_reg;
    logic                        sel_next;
    logic [CBO_LINES-1:0]        lines_reg;
    logic [CBO_LINES-1:0]        lines_next;
    logic [7:0]                  query_reg;

    // Second read port: the query side must not disturb the sweep read
    logic [7:0]                  query_value;

    cbo_store #(
        .NUM_CH (NUM_CH),
        .CH_W   (CH_W)
    ) u_store (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_wr       (i_wr),
        .i_rd_chan  (i_sweep.chan),
        .o_rd_value (sweep_value)
    );

    // Mirror store for queries keeps one read port per copy
    cbo_store #(
        .NUM_CH (NUM_CH),
        .CH_W   (CH_W)
    ) u_query (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_wr       (i_wr),
        .i_rd_chan  (i_query_chan),
        .o_rd_value (query_value)
    );

    function automatic logic [CBO_LINES-1:0] map_lines(input logic [7:0] v, input logic sel,
                                                       input logic [CBO_DRV_PORTS-1:0] drv);
        logic [CBO_LINES-1:0] r;
        r = v;
        if (!sel) begin
            r[CBO_LINES-1:CBO_LOW_W] = drv;
        end
        return r;
    endfunction

    always_comb begin
        shown_chan_next = shown_chan_reg;
        ch_value_next   = ch_value_reg;
        sel_next        = sel_reg;
        if (i_upper_select_wr) begin
            sel_next = i_upper_line_source_select;
        end
        // Idle only blocks new sweeps; a stored write never moves the lines by itself
        if (i_sweep.start && !i_sweep.idle) begin
            shown_chan_next = i_sweep.chan;
            ch_value_next   = sweep_value;
        end
        // Lines change on sweep events, on a select change, and every cycle while drive ports are shown; else held
        lines_next = map_lines(ch_value_next, sel_next, i_drive_port);
        if (!(i_sweep.start && !i_sweep.idle) && sel_next == sel_reg && sel_reg) begin
            lines_next = lines_reg;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shown_chan_reg <= '0;
            ch_value_reg   <= CBO_VALUE_RST;
            sel_reg        <= CBO_UPPER_RST;
            lines_reg      <= '0;
            query_reg      <= CBO_VALUE_RST;
        end else begin
            shown_chan_reg <= shown_chan_next;
            ch_value_reg   <= ch_value_next;
            sel_reg        <= sel_next;
            lines_reg      <= lines_next;
            query_reg      <= query_value;
        end
    end

    assign o_aux_connector_output_value = lines_reg;
    assign o_upper_line_source_select   = sel_reg;
    assign o_query_value                = query_reg;

    sequence s_sweep_start;
        i_sweep.start && !i_sweep.idle && sel_reg && !i_upper_select_wr;
    endsequence

    property p_follow_sweep;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_sweep_start |=> o_aux_connector_output_value == $past(sweep_value);
    endproperty
    a_follow_sweep: assert property (p_follow_sweep) else $error("lines do not show sweep value");

    property p_hold_idle;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (i_sweep.idle && sel_reg && !i_upper_select_wr) |=> $stable(o_aux_connector_output_value);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("lines changed while idle");

    property p_drive_upper;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !sel_reg |-> o_aux_connector_output_value[CBO_LINES-1:CBO_LOW_W] == $past(i_drive_port)
                     || $past(sel_reg);
    endproperty
    a_drive_upper: assert property (p_drive_upper) else $error("upper lines not drive ports");

    property p_low_bits;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_sweep_start ##1 1'b1 |-> o_aux_connector_output_value[CBO_LOW_W-1:0] == ch_value_reg[CBO_LOW_W-1:0];
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low lines mismatch value");

    property p_query;
        @(posedge i_mclk) disable iff (i_sys_rst)
        1'b1 |=> o_query_value == $past(query_value);
    endproperty
    a_query: assert property (p_query) else $error("query value wrong");

    property p_no_event_stable;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (!i_sweep.start && sel_reg && !i_upper_select_wr) |=> $stable(o_aux_connector_output_value);
    endproperty
    a_no_event_stable: assert property (p_no_event_stable) else $error("lines moved without event");

    property p_sel_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_upper_select_wr |=> o_upper_line_source_select == $past(i_upper_line_source_select);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select not written");

    // A start that the sequencer really takes, whatever the select
    sequence s_taken_start;
        i_sweep.start && !i_sweep.idle;
    endsequence

    // Return to channel bits while drive ports were shown
    sequence s_select_back;
        !sel_reg && i_upper_select_wr && i_upper_line_source_select && !(i_sweep.start && !i_sweep.idle);
    endsequence

    // No disable here: reset itself is the antecedent
    property p_reset_values;
        @(posedge i_mclk)
        i_sys_rst |-> o_aux_connector_output_value == '0 && o_upper_line_source_select == CBO_UPPER_RST
                      && o_query_value == CBO_VALUE_RST;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("outputs not cleared in reset");

    property p_shown_chan;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_taken_start |=> shown_chan_reg == $past(i_sweep.chan);
    endproperty
    a_shown_chan: assert property (p_shown_chan) else $error("sweeping channel not recorded");

    property p_capture_value;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_taken_start |=> ch_value_reg == $past(sweep_value);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("sweep value not captured");

    property p_idle_freeze;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_sweep.idle |=> $stable(ch_value_reg) && $stable(shown_chan_reg);
    endproperty
    a_idle_freeze: assert property (p_idle_freeze) else $error("start taken while idle");

    // Port indication is live, one registered cycle behind
    property p_drive_live;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (!sel_reg && !i_upper_select_wr)
            |=> o_aux_connector_output_value[CBO_LINES-1:CBO_LOW_W] == $past(i_drive_port);
    endproperty
    a_drive_live: assert property (p_drive_live) else $error("upper lines lag drive ports");

    // Lower lines keep the last sweep value while ports are shown
    property p_low_keep;
        @(posedge i_mclk) disable iff (i_sys_rst)
        (!sel_reg && !i_upper_select_wr && !i_sweep.start) |=> $stable(o_aux_connector_output_value[CBO_LOW_W-1:0]);
    endproperty
    a_low_keep: assert property (p_low_keep) else $error("lower lines moved without sweep");

    property p_select_back;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_select_back |=> o_aux_connector_output_value == $past(ch_value_reg);
    endproperty
    a_select_back: assert property (p_select_back) else $error("channel bits not restored");

    property p_sel_hold;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_upper_select_wr |=> $stable(o_upper_line_source_select);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved without write");

    // A write is visible on the query two edges later
    property p_query_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr.valid ##1 (i_query_chan == $past(i_wr.chan)) |=> o_query_value == $past(i_wr.value, 2);
    endproperty
    a_query_write: assert property (p_query_write) else $error("query misses written value");
endmodule

// file: cbo_store.sv
// Per-channel value store with an indexed write port and a read port.
// Assumes writes arrive from logic on the same clock.
`timescale 1ns/1ps
module cbo_store #(
    parameter int NUM_CH = cbo_pkg::CBO_NUM_CH,
    parameter int CH_W   = cbo_pkg::CBO_CH_W
) (
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire cbo_pkg::cbo_wr_t i_wr,
    input  wire logic [CH_W-1:0]  i_rd_chan,
    output logic [7:0]            o_rd_value
);
    import cbo_pkg::*;

    logic [7:0] mem_reg  [NUM_CH];
    logic [7:0] mem_next [NUM_CH];

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (i_wr.valid) begin
            mem_next[i_wr.chan] = i_wr.value;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                mem_reg[i] <= CBO_VALUE_RST;
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign o_rd_value = mem_reg[i_rd_chan];

    property p_store_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_wr.valid |=> mem_reg[$past(i_wr.chan)] == $past(i_wr.value);
    endproperty
    a_store_write: assert property (p_store_write) else $error("stored value not written");
endmodule

// file: tb_top.sv
// Self-checking bench for the aux connector output port.
// Assumes stimulus at falling edges, design sampling at rising edges.
`timescale 1ns/1ps
module tb_top;
    import cbo_pkg::*;
    logic       i_mclk, i_sys_rst, sel, sel_wr, sel_q, sel_now, took;
    cbo_wr_t    wr;
    cbo_sweep_t sw;
    logic [2:0] qch;
    logic [7:0] qv, lines, last;
    logic [3:0] drv;
    logic [7:0] mem [8];
    logic [7:0] exp_q [$];
    int         n_fail, checks, seed, edges, e0;

    cbo_port uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wr(wr), .i_query_chan(qch), .o_query_value(qv),
        .i_sweep(sw), .i_upper_line_source_select(sel), .i_upper_select_wr(sel_wr), .i_drive_port(drv),
        .o_upper_line_source_select(sel_q), .o_aux_connector_output_value(lines));
    cbo_ext_equip ext (.i_mclk(i_mclk), .i_lines(lines), .o_edges(edges));

    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        checks++;
        if (seen !== expv) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [7:0] exp_lines(input logic [7:0] v);
        return sel_now ? v : {drv, v[3:0]};
    endfunction
    task automatic wr_ch(input logic [2:0] ch, input logic [7:0] v);
        @(negedge i_mclk);
        wr = '{1'b1, ch, v};
        mem[ch] = v;
        @(negedge i_mclk);
        wr.valid = 1'b0;
    endtask
    task automatic query(input logic [2:0] ch);
        @(negedge i_mclk);
        qch = ch;
        @(negedge i_mclk);
        check(qv, mem[ch]);
    endtask
    task automatic sweep(input logic [2:0] ch);
        @(negedge i_mclk);
        sw.start = 1'b1;
        sw.chan = ch;
        if (!sw.idle) begin
            exp_q.push_back(exp_lines(mem[ch]));
            last = mem[ch];
        end
        @(negedge i_mclk);
        sw.start = 1'b0;
    endtask
    task automatic set_sel(input logic s);
        @(negedge i_mclk);
        sel = s;
        sel_wr = 1'b1;
        @(negedge i_mclk);
        sel_wr = 1'b0;
        sel_now = s;
        check({7'h00, sel_q}, {7'h00, s});
        @(negedge i_mclk);
        check(lines, exp_lines(last));
    endtask

    // Result watcher: one note per taken sweep start
    always @(posedge i_mclk) took <= sw.start && !sw.idle && !i_sys_rst;
    always @(negedge i_mclk) if (took) check(lines, exp_q.pop_front());

    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    initial begin
        #100us;
        n_fail++;
        print_verdict();
    end
    initial begin
        i_sys_rst = 1'b1; wr = '0; sw = '0; qch = 3'h0; sel = 1'b1; sel_wr = 1'b0; drv = 4'h0;
        sel_now = 1'b1; last = 8'h00; n_fail = 0; checks = 0; seed = 28;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (8) @(negedge i_mclk);
        check(lines, 8'h00);
        check({7'h00, sel_q}, 8'h01);
        i_sys_rst = 1'b0;
        for (int c = 0; c < 8; c++) query(3'(c));
        for (int c = 0; c < 8; c++) wr_ch(3'(c), 8'($random(seed)));
        wr_ch(3'h0, 8'h02);
        wr_ch(3'h7, 8'hff);
        wr_ch(3'h3, 8'h00);
        for (int c = 0; c < 8; c++) query(3'(c));
        for (int c = 7; c >= 0; c--) sweep(3'(c));
        sweep(3'h3);
        sweep(3'h7);
        // Writes alone must not move the lines; let the last sweep's change be counted first
        @(negedge i_mclk);
        e0 = edges;
        wr_ch(3'h7, 8'h5a);
        wr_ch(3'h1, 8'hc3);
        repeat (2) @(negedge i_mclk);
        check(8'(edges - e0), 8'h00);
        check(lines, 8'hff);
        @(negedge i_mclk);
        sw.idle = 1'b1;
        sweep(3'h1);
        repeat (2) @(negedge i_mclk);
        check(lines, 8'hff);
        sw.idle = 1'b0;
        drv = 4'($random(seed));
        set_sel(1'b0);
        sweep(3'h1);
        sweep(3'h0);
        set_sel(1'b1);
        set_sel(1'b0);
        // Mid-run reset clears stored values and sets the select back to 1
        @(negedge i_mclk);
        i_sys_rst = 1'b1;
        sel_now = 1'b1;
        last = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        @(negedge i_mclk);
        check(lines, 8'h00);
        check({7'h00, sel_q}, 8'h01);
        i_sys_rst = 1'b0;
        for (int c = 0; c < 8; c++) query(3'(c));
        sweep(3'h5);
        set_sel(1'b1);
        repeat (3) @(negedge i_mclk);
        print_verdict();
    end
endmodule
